// ==== logic/rcss_pkg.sv ====
// reset and clock start-up sequencer: shared constants and types
// assumes the block clock is the oscillator clock, so one cycle is one oscillator cycle
package rcss_pkg;

   // ****************************************************************
   // timing, figures in oscillator cycles except SEQ_CNT_W, a width in bits
   // ****************************************************************
   localparam int unsigned CLK_PER_OSC     = 1;       // block cycles per oscillator cycle
   localparam int unsigned WDOG_PULSE_OSC  = 512;     // watchdog reset pulse length
   localparam int unsigned BUS_VALID_OSC   = 32;      // release to valid address and data
   localparam int unsigned BOOT_HOLD_OSC   = 200;     // boot pins hold window after release
   localparam int unsigned BOOT_SAMPLE_OSC = 16;      // boot pins sampled here, inside the window
   localparam int unsigned PIN_LAT_CYC     = 3;       // pin rise to core release: two syncs, one flop
   localparam int unsigned PLL_LOCK_OSC    = 131072;  // pll lock time
   localparam int unsigned WDOG_PULSE_CYC  = WDOG_PULSE_OSC * CLK_PER_OSC;
   localparam int unsigned BUS_VALID_CYC   = BUS_VALID_OSC * CLK_PER_OSC;
   localparam int unsigned BOOT_SAMPLE_CYC = BOOT_SAMPLE_OSC * CLK_PER_OSC;
   localparam int unsigned PLL_LOCK_CYC    = PLL_LOCK_OSC * CLK_PER_OSC;
   localparam int unsigned SEQ_CNT_W       = 10;      // holds the longest sequencer count

   // ****************************************************************
   // clock selections and reset values
   // ****************************************************************
   localparam logic [1:0] DIV_SEL_BY4     = 2'h0;    // clock output = system clock / 4
   localparam logic [1:0] DIV_SEL_BY2     = 2'h1;    // clock output = system clock / 2
   localparam logic [1:0] CLKOUT_DIV_RST  = 2'h0;    // clkout_div_sel after reset
   localparam int unsigned MULT_W         = 4;       // width of the pll multiplier
   localparam logic [3:0] PLL_MULT_BYPASS = 4'h0;    // pll bypassed, system clock = osc / 2

   // ****************************************************************
   // sequencer states, gray along hold, start, run, watchdog
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_HOLD  = 2'h0,
      ST_START = 2'h1,
      ST_RUN   = 2'h3,
      ST_WDOG  = 2'h2
   } rcss_state_t;

endpackage : rcss_pkg

// ==== logic/rcss_clk_if.sv ====
// carrier between the sequencer and its clock divider
// assumes both ends run on the oscillator clock
`timescale 1ns/1ps
`default_nettype none
interface rcss_clk_if;
   logic       run;        // core out of reset
   logic       half_mode;  // system clock at osc / 2
   logic [1:0] div_sel;    // clkout_div_sel
   logic       sysclk_en;  // one-cycle system clock enable
   logic       pin;        // clock_output_pin level

   modport ctl (output run, output half_mode, output div_sel, input sysclk_en, input pin);
   modport div (input run, input half_mode, input div_sel, output sysclk_en, output pin);
endinterface : rcss_clk_if
`default_nettype wire

// ==== logic/rcss_clkdiv.sv ====
// system clock enable and clock output divider
// assumes run, half_mode and div_sel come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module rcss_clkdiv (
   input  wire logic i_clk,     // oscillator clock
   input  wire logic i_resetn,  // synchronous reset, active low
   rcss_clk_if.div   bus        // controls in, enable and pin out
);

   logic phase;
   logic next_phase;
   logic en;
   logic next_en;
   logic half_cnt;
   logic next_half_cnt;
   logic pin;
   logic next_pin;

   // ****************************************************************
   // divider
   // ****************************************************************

   // enable every other cycle in half mode, then count enables for the pin
   always_comb begin
      next_phase    = 1'b0;
      next_en       = 1'b0;
      next_half_cnt = half_cnt;
      next_pin      = pin;
      if (!bus.run) begin
         next_half_cnt = 1'b0;
         next_pin      = 1'b0;
      end else begin
         if (bus.half_mode) begin
            next_phase = ~phase;
            next_en    = phase;                     // [R6] [R8]
         end else begin
            next_en    = 1'b1;
         end
         if (en) begin
            unique case (bus.div_sel)
               rcss_pkg::DIV_SEL_BY4: begin
                  next_half_cnt = ~half_cnt;
                  if (half_cnt) begin
                     next_pin = ~pin;               // [R7]
                  end
               end
               rcss_pkg::DIV_SEL_BY2: begin
                  next_pin = ~pin;
               end
               default: begin
                  next_pin = 1'b0;                  // remaining codes hold the pin low
               end
            endcase
         end
      end
   end

   // registers only
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         phase    <= 1'b0;
         en       <= 1'b0;
         half_cnt <= 1'b0;
         pin      <= 1'b0;
      end else begin
         phase    <= next_phase;
         en       <= next_en;
         half_cnt <= next_half_cnt;
         pin      <= next_pin;
      end
   end

   assign bus.sysclk_en = en;
   assign bus.pin       = pin;

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_sys_half;
      @(posedge i_clk) disable iff (!i_resetn || !bus.run)
      bus.half_mode && bus.sysclk_en |=> !bus.sysclk_en ##1 (bus.sysclk_en || !bus.half_mode);
   endproperty
   a_sys_half: assert property (p_sys_half) else $error("system clock not at osc / 2"); // [R6]

   property p_clkout_eighth;
      @(posedge i_clk) disable iff (!i_resetn || !bus.run || !bus.half_mode
                                    || bus.div_sel != rcss_pkg::DIV_SEL_BY4)
      $rose(bus.pin) && $past(bus.half_mode) |-> bus.pin[*4] ##1 !bus.pin[*4] ##1 bus.pin;
   endproperty
   a_clkout_eighth: assert property (p_clkout_eighth) else $error("clock output not osc / 8"); // [R7]

endmodule : rcss_clkdiv
`default_nettype wire

// ==== logic/rcss_top.sv ====
// reset and clock start-up sequencer, top level
// assumes i_clk is the oscillator clock; the reset pin and boot pins are asynchronous,
// watchdog trip and the write strobes come from logic on i_clk
//
// Notes on behaviour
// (R1) at power-up the reset pin stays low 8 cycles after clock is stable
// (R2) a warm reset holds the reset pin low at least 8 cycles
// (R3) a watchdog trip drives a reset pulse of 512 cycles
// (R4) address and data become valid 32 cycles after the reset pin rises
// (R5) boot pins stay steady 200 cycles after release so they sample cleanly
// (R6) after reset the system clock runs at half the oscillator rate
// (R7) clock divider select resets to 0, dividing system clock by 4
// (R8) a new pll multiplier runs at half rate for 131072 cycles, then switches
// (R9) core stays in reset while the pin is low, starts on first high edge
`timescale 1ns/1ps
`default_nettype none
module rcss_top #(
   parameter int unsigned BOOT_W   = 4,                        // boot-mode pin count
   parameter int unsigned LOCK_CYC = rcss_pkg::PLL_LOCK_CYC    // pll lock cycles
) (
   input  wire logic                   i_clk,               // oscillator clock, 40 MHz
   input  wire logic                   i_resetn,            // synchronous reset, active low
   input  wire logic                   i_ext_reset_n,       // ext_reset_n pin, asynchronous
   input  wire logic                   i_wdog_trip,         // watchdog trip pulse
   input  wire logic [BOOT_W-1:0]      i_boot_mode,         // boot-mode pins, asynchronous
   input  wire logic                   i_pll_wr,            // write pll_ratio_ctl
   input  wire logic [rcss_pkg::MULT_W-1:0] i_pll_mult,     // new multiplier
   input  wire logic                   i_clkout_div_wr,     // write clkout_div_sel
   input  wire logic [1:0]             i_clkout_div,        // new clkout_div_sel
   output logic                        o_core_resetn,       // internal reset, active low
   output logic                        o_wdog_reset_n,      // watchdog reset pulse, active low
   output logic                        o_bus_valid,         // address and data valid
   output logic [BOOT_W-1:0]           o_boot_mode,         // sampled boot mode
   output logic                        o_boot_valid,        // boot mode captured
   output logic                        o_sysclk_en,         // system_clock enable pulse
   output logic                        o_clock_output_pin,  // clock_output_pin
   output logic                        o_sys_half,          // system clock at osc / 2
   output logic                        o_pll_busy,          // pll relock in progress
   output logic [rcss_pkg::MULT_W-1:0] o_pll_mult           // multiplier in force
);

   localparam int unsigned LOCK_W = $clog2(LOCK_CYC + 1);
   localparam int unsigned CW     = rcss_pkg::SEQ_CNT_W;

   rcss_clk_if clk_bus ();

   logic                       pin_s1;
   logic                       pin_s2;
   logic [BOOT_W-1:0]          boot_s1;
   logic [BOOT_W-1:0]          boot_s2;
   rcss_pkg::rcss_state_t      state;
   rcss_pkg::rcss_state_t      next_state;
   logic [CW-1:0]              cnt;
   logic [CW-1:0]              next_cnt;
   logic                       next_core_resetn;
   logic                       next_wdog_reset_n;
   logic                       next_bus_valid;
   logic [BOOT_W-1:0]          next_boot_mode;
   logic                       next_boot_valid;
   logic                       next_pll_busy;
   logic                       next_sys_half;
   logic [rcss_pkg::MULT_W-1:0] next_pll_mult;
   logic [rcss_pkg::MULT_W-1:0] pend_mult;
   logic [rcss_pkg::MULT_W-1:0] next_pend_mult;
   logic [LOCK_W-1:0]          lock_cnt;
   logic [LOCK_W-1:0]          next_lock_cnt;
   logic [1:0]                 div_sel;
   logic [1:0]                 next_div_sel;
   logic [CW-1:0]              h_wlow;

   // ****************************************************************
   // input synchronisers
   // ****************************************************************

   // two flops on the reset pin and the boot pins
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         pin_s1  <= 1'b0;
         pin_s2  <= 1'b0;
         boot_s1 <= '0;
         boot_s2 <= '0;
      end else begin
         pin_s1  <= i_ext_reset_n;
         pin_s2  <= pin_s1;
         boot_s1 <= i_boot_mode;
         boot_s2 <= boot_s1;
      end
   end

   // ****************************************************************
   // reset sequencer
   // ****************************************************************

   // hold, start-up count, run, watchdog pulse
   always_comb begin
      next_state        = state;
      next_cnt          = cnt;
      next_core_resetn  = o_core_resetn;
      next_wdog_reset_n = 1'b1;
      next_bus_valid    = o_bus_valid;
      next_boot_mode    = o_boot_mode;
      next_boot_valid   = o_boot_valid;
      unique case (state)
         rcss_pkg::ST_HOLD: begin
            next_cnt         = '0;
            next_core_resetn = 1'b0;                                        // [R9]
            next_bus_valid   = 1'b0;
            next_boot_valid  = 1'b0;
            if (pin_s2) begin
               next_state       = rcss_pkg::ST_START;
               next_core_resetn = 1'b1;                                     // [R9]
            end
         end
         rcss_pkg::ST_START, rcss_pkg::ST_RUN: begin
            if (state == rcss_pkg::ST_START) begin
               next_cnt = cnt + CW'(1);
               if (cnt == CW'(rcss_pkg::BOOT_SAMPLE_CYC - 1)) begin
                  next_boot_mode  = boot_s2;                                // [R5]
                  next_boot_valid = 1'b1;
               end
               // the pin latency already spent part of the window after the pin rose
               if (cnt == CW'(rcss_pkg::BUS_VALID_CYC - rcss_pkg::PIN_LAT_CYC - 1)) begin
                  next_bus_valid = 1'b1;                                    // [R4]
                  next_state     = rcss_pkg::ST_RUN;
               end
            end
            if (!pin_s2) begin
               next_state       = rcss_pkg::ST_HOLD;                        // [R9]
               next_core_resetn = 1'b0;
               next_bus_valid   = 1'b0;
            end else if (i_wdog_trip) begin
               next_state        = rcss_pkg::ST_WDOG;
               next_cnt          = '0;
               next_wdog_reset_n = 1'b0;                                    // [R3]
               next_core_resetn  = 1'b0;
               next_bus_valid    = 1'b0;
            end
         end
         rcss_pkg::ST_WDOG: begin
            next_cnt          = cnt + CW'(1);
            next_wdog_reset_n = 1'b0;
            if (cnt == CW'(rcss_pkg::WDOG_PULSE_CYC - 1)) begin
               next_wdog_reset_n = 1'b1;                                    // [R3]
               next_state        = rcss_pkg::ST_HOLD;
            end
         end
      endcase
   end

   // registers only
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state          <= rcss_pkg::ST_HOLD;
         cnt            <= '0;
         o_core_resetn  <= 1'b0;
         o_wdog_reset_n <= 1'b1;
         o_bus_valid    <= 1'b0;
         o_boot_mode    <= '0;
         o_boot_valid   <= 1'b0;
      end else begin
         state          <= next_state;
         cnt            <= next_cnt;
         o_core_resetn  <= next_core_resetn;
         o_wdog_reset_n <= next_wdog_reset_n;
         o_bus_valid    <= next_bus_valid;
         o_boot_mode    <= next_boot_mode;
         o_boot_valid   <= next_boot_valid;
      end
   end

   // ****************************************************************
   // pll ratio and clock output select
   // ****************************************************************

   // reset values while core is held, relock at half rate on a ratio write
   always_comb begin
      next_pll_busy  = o_pll_busy;
      next_sys_half  = o_sys_half;
      next_pll_mult  = o_pll_mult;
      next_pend_mult = pend_mult;
      next_lock_cnt  = lock_cnt;
      next_div_sel   = div_sel;
      if (!o_core_resetn) begin
         next_pll_busy  = 1'b0;
         next_sys_half  = 1'b1;                                             // [R6]
         next_pll_mult  = rcss_pkg::PLL_MULT_BYPASS;
         next_pend_mult = rcss_pkg::PLL_MULT_BYPASS;
         next_lock_cnt  = '0;
         next_div_sel   = rcss_pkg::CLKOUT_DIV_RST;                         // [R7]
      end else begin
         if (i_clkout_div_wr) begin
            next_div_sel = i_clkout_div;
         end
         if (i_pll_wr) begin
            next_pend_mult = i_pll_mult;
            next_pll_busy  = 1'b1;
            next_sys_half  = 1'b1;                                          // [R8]
            next_lock_cnt  = '0;
         end else if (o_pll_busy) begin
            next_lock_cnt = lock_cnt + LOCK_W'(1);
            if (lock_cnt == LOCK_W'(LOCK_CYC - 1)) begin
               next_pll_busy = 1'b0;                                        // [R8]
               next_pll_mult = pend_mult;
               next_sys_half = (pend_mult == rcss_pkg::PLL_MULT_BYPASS);
            end
         end
      end
   end

   // registers only
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_pll_busy <= 1'b0;
         o_sys_half <= 1'b1;
         o_pll_mult <= rcss_pkg::PLL_MULT_BYPASS;
         pend_mult  <= rcss_pkg::PLL_MULT_BYPASS;
         lock_cnt   <= '0;
         div_sel    <= rcss_pkg::CLKOUT_DIV_RST;
      end else begin
         o_pll_busy <= next_pll_busy;
         o_sys_half <= next_sys_half;
         o_pll_mult <= next_pll_mult;
         pend_mult  <= next_pend_mult;
         lock_cnt   <= next_lock_cnt;
         div_sel    <= next_div_sel;
      end
   end

   // ****************************************************************
   // clock divider
   // ****************************************************************
   assign clk_bus.run       = o_core_resetn;
   assign clk_bus.half_mode = o_sys_half;
   assign clk_bus.div_sel   = div_sel;
   assign o_sysclk_en        = clk_bus.sysclk_en;
   assign o_clock_output_pin = clk_bus.pin;

   rcss_clkdiv u_div (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .bus      (clk_bus.div)
   );

   // ****************************************************************
   // checks
   // ****************************************************************

   // length of the current watchdog pulse
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         h_wlow <= '0;
      end else begin
         h_wlow <= o_wdog_reset_n ? '0 : h_wlow + CW'(1);
      end
   end

   property p_wdog_pulse;
      @(posedge i_clk) disable iff (!i_resetn)
      $rose(o_wdog_reset_n) |-> h_wlow == CW'(rcss_pkg::WDOG_PULSE_CYC);
   endproperty
   a_wdog_pulse: assert property (p_wdog_pulse) else $error("watchdog pulse length wrong"); // [R3]

   property p_bus_valid;
      @(posedge i_clk) disable iff (!i_resetn || !o_core_resetn || !o_wdog_reset_n)
      $rose(o_core_resetn) |-> !o_bus_valid ##28 !o_bus_valid ##1 o_bus_valid;
   endproperty
   a_bus_valid: assert property (p_bus_valid) else $error("bus valid not 32 cycles"); // [R4]

   property p_core_hold;
      @(posedge i_clk) disable iff (!i_resetn)
      !pin_s2 |=> !o_core_resetn && !o_bus_valid;
   endproperty
   a_core_hold: assert property (p_core_hold) else $error("core left reset with pin low"); // [R9]

   property p_core_start;
      @(posedge i_clk) disable iff (!i_resetn)
      state == rcss_pkg::ST_HOLD && pin_s2 |=> o_core_resetn;
   endproperty
   a_core_start: assert property (p_core_start) else $error("start-up did not begin"); // [R9]

   property p_reset_defaults;
      @(posedge i_clk) disable iff (!i_resetn)
      !o_core_resetn |=> o_sys_half && div_sel == rcss_pkg::CLKOUT_DIV_RST;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("reset clock defaults wrong"); // [R7]

   property p_lock_half;
      @(posedge i_clk) disable iff (!i_resetn)
      o_core_resetn && i_pll_wr |=> o_pll_busy && o_sys_half && lock_cnt == '0;
   endproperty
   a_lock_half: assert property (p_lock_half) else $error("relock not at half rate"); // [R8]

   property p_lock_done;
      @(posedge i_clk) disable iff (!i_resetn || !o_core_resetn)
      o_pll_busy && !i_pll_wr && lock_cnt == LOCK_W'(LOCK_CYC - 1)
         |=> !o_pll_busy && o_pll_mult == $past(pend_mult);
   endproperty
   a_lock_done: assert property (p_lock_done) else $error("pll switch not at lock count"); // [R8]

   property p_busy_half;
      @(posedge i_clk) disable iff (!i_resetn)
      o_pll_busy |-> o_sys_half;
   endproperty
   a_busy_half: assert property (p_busy_half) else $error("full rate during relock"); // [R8]

endmodule : rcss_top
`default_nettype wire

// ==== dv/rcss_supervisor.sv ====
// partner model: external reset supervisor and boot-mode strap logic
// assumes the bench pulses i_go for one cycle; the pin low time is i_low_cyc oscillator cycles, raised to 8 when smaller
`timescale 1ns/1ps
`default_nettype none
module rcss_supervisor #(
   parameter int unsigned BOOT_W    = 4,    // boot-mode pin count
   parameter int unsigned BOOT_HOLD = 200   // boot pins hold window after release
) (
   input  wire logic              i_clk,          // oscillator clock
   input  wire logic              i_go,           // start a reset, one-cycle pulse
   input  wire logic [15:0]       i_low_cyc,      // requested low time of the reset pin
   input  wire logic [BOOT_W-1:0] i_boot_val,     // boot mode to present
   output logic                   o_ext_reset_n,  // ext_reset_n pin
   output logic [BOOT_W-1:0]      o_boot_mode     // boot-mode pins
);
   // ****************************************************************
   // reset pin and boot pins
   // ****************************************************************
   int unsigned low_cnt;
   int unsigned hold_cnt;

   // pin starts low at power-up, before the clock is stable
   initial begin
      o_ext_reset_n = 1'b0;
      o_boot_mode   = '0;
      low_cnt       = 0;
      hold_cnt      = 0;
   end

   // drives the pin low, releases it, then holds the straps for the window
   always @(posedge i_clk) begin
      if (i_go) begin
         low_cnt       <= (i_low_cyc < 16'h0008) ? 8 : int'(i_low_cyc);
         o_ext_reset_n <= 1'b0;
         o_boot_mode   <= i_boot_val;
      end else if (low_cnt > 1) begin
         low_cnt <= low_cnt - 1;
      end else if (low_cnt == 1) begin
         low_cnt       <= 0;
         o_ext_reset_n <= 1'b1;
         hold_cnt      <= BOOT_HOLD;
      end else if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
      end else begin
         o_boot_mode <= ~o_boot_mode;  // hold over: straps no longer trustworthy
      end
   end
endmodule : rcss_supervisor
`default_nettype wire

// ==== dv/rcss_tb.sv ====
// self-checking bench for the reset and clock start-up sequencer
// assumes rcss_top with LOCK_CYC shortened to 16 and the supervisor model on the pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin errors++; $display("FAIL %0t %s", $time, msg); end end
module rcss_tb;
   localparam int unsigned LOCK = 16;  // shortened pll lock
   logic       i_clk, i_resetn, i_wdog_trip, i_pll_wr, i_clkout_div_wr, sup_go;
   logic [3:0] i_pll_mult, sup_boot, boot_pins, o_boot_mode, o_pll_mult;
   logic [1:0] i_clkout_div;
   logic [15:0] sup_low;
   logic       ext_reset_n, o_core_resetn, o_wdog_reset_n, o_bus_valid, o_boot_valid;
   logic       o_sysclk_en, o_clock_output_pin, o_sys_half, o_pll_busy;
   int         errors, n_checks;

   // ****************************************************************
   // clock, model and device
   // ****************************************************************
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   rcss_supervisor #(.BOOT_W(4), .BOOT_HOLD(200)) i_sup (.i_clk(i_clk), .i_go(sup_go),
      .i_low_cyc(sup_low), .i_boot_val(sup_boot), .o_ext_reset_n(ext_reset_n),
      .o_boot_mode(boot_pins));

   rcss_top #(.BOOT_W(4), .LOCK_CYC(LOCK)) i_dut (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_ext_reset_n(ext_reset_n), .i_wdog_trip(i_wdog_trip), .i_boot_mode(boot_pins),
      .i_pll_wr(i_pll_wr), .i_pll_mult(i_pll_mult), .i_clkout_div_wr(i_clkout_div_wr),
      .i_clkout_div(i_clkout_div), .o_core_resetn(o_core_resetn),
      .o_wdog_reset_n(o_wdog_reset_n), .o_bus_valid(o_bus_valid), .o_boot_mode(o_boot_mode),
      .o_boot_valid(o_boot_valid), .o_sysclk_en(o_sysclk_en),
      .o_clock_output_pin(o_clock_output_pin), .o_sys_half(o_sys_half),
      .o_pll_busy(o_pll_busy), .o_pll_mult(o_pll_mult));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report

   // one edge, then let its updates land
   task automatic tick();
      @(posedge i_clk);
      #1;
   endtask : tick

   // cuts a hang short
   task automatic guard(input int n, input int lim);
      if (n > lim) begin
         errors++;
         $display("FAIL %0t wait ran out", $time);
         final_report();
      end
   endtask : guard

   // asks the supervisor for a reset and waits for the pin to rise
   task automatic pin_reset(input logic [15:0] low, input logic [3:0] bv);
      int n;
      n = 0;
      @(posedge i_clk);
      sup_go   <= 1'b1;
      sup_low  <= low;
      sup_boot <= bv;
      @(posedge i_clk);
      sup_go <= 1'b0;
      #1;
      while (ext_reset_n !== 1'b1) begin tick(); n++; guard(n, 100); end
      `CHK(o_core_resetn, 1'b0, "core out of reset while pin low")
   endtask : pin_reset

   // start-up walk after the pin or a watchdog pulse releases the core
   task automatic chk_start(input logic [3:0] bv, input bit boot);
      int   n;
      logic prev;
      n = 0;
      while (o_core_resetn !== 1'b1) begin tick(); n++; guard(n, 4); end
      `CHK(o_sys_half, 1'b1, "system clock not half rate")
      `CHK(o_pll_mult, rcss_pkg::PLL_MULT_BYPASS, "pll not bypassed")
      prev = o_sysclk_en;
      for (int i = 1; i <= 32; i++) begin
         tick();
         `CHK(o_bus_valid, logic'(i >= int'(rcss_pkg::BUS_VALID_CYC - rcss_pkg::PIN_LAT_CYC)), "bus valid timing")
         if (boot) `CHK(o_boot_valid, logic'(i >= 16), "boot capture timing")
         if (i > 2) `CHK(o_sysclk_en, ~prev, "enable not every 2nd cycle")
         prev = o_sysclk_en;
      end
      if (boot) `CHK(o_boot_mode, bv, "boot mode value")
   endtask : chk_start

   // clock output pin: h cycles high then h low
   task automatic chk_pin(input int h);
      int n;
      n = 0;
      while (o_clock_output_pin !== 1'b0) begin tick(); n++; guard(n, 20); end
      while (o_clock_output_pin !== 1'b1) begin tick(); n++; guard(n, 20); end
      for (int i = 0; i < 2 * h; i++) begin
         `CHK(o_clock_output_pin, logic'(i < h), "clock output shape")
         tick();
      end
   endtask : chk_pin

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_powerup();
      pin_reset(16'h000c, 4'ha);
      chk_start(4'ha, 1'b1);
      chk_pin(4);  // osc / 8 at power-up
      $display("test powerup done");
   endtask : t_powerup

   task automatic t_warm_div();
      @(posedge i_clk);
      i_clkout_div_wr <= 1'b1;
      i_clkout_div    <= rcss_pkg::DIV_SEL_BY2;
      @(posedge i_clk);
      i_clkout_div_wr <= 1'b0;
      chk_pin(2);
      @(posedge i_clk);
      i_clkout_div_wr <= 1'b1;
      i_clkout_div    <= 2'h2;
      @(posedge i_clk);
      i_clkout_div_wr <= 1'b0;
      repeat (3) tick();
      for (int i = 0; i < 8; i++) begin
         `CHK(o_clock_output_pin, 1'b0, "unused select not held low")
         tick();
      end
      pin_reset(16'h0008, 4'h5);  // shortest warm reset
      chk_start(4'h5, 1'b1);
      chk_pin(4);  // select back at its reset value
      $display("test warm reset done");
   endtask : t_warm_div

   task automatic t_wdog();
      int n;
      n = 1;
      @(posedge i_clk);
      i_wdog_trip <= 1'b1;
      @(posedge i_clk);
      i_wdog_trip <= 1'b0;
      #1;
      `CHK(o_core_resetn, 1'b0, "core not reset by watchdog")
      while (o_wdog_reset_n === 1'b0) begin tick(); n++; guard(n, 600); end
      `CHK(n, 513, "watchdog pulse length")
      chk_start(4'h0, 1'b0);
      $display("test watchdog done");
   endtask : t_wdog

   task automatic t_pll();
      logic [3:0] mults [2];
      int         n;
      mults = '{4'h4, rcss_pkg::PLL_MULT_BYPASS};
      foreach (mults[k]) begin
         n = 1;
         @(posedge i_clk);
         i_pll_wr   <= 1'b1;
         i_pll_mult <= mults[k];
         @(posedge i_clk);
         i_pll_wr <= 1'b0;
         #1;
         while (o_pll_busy === 1'b1) begin
            `CHK(o_sys_half, 1'b1, "not half rate during relock")
            tick();
            n++;
            guard(n, 40);
         end
         `CHK(n, int'(LOCK) + 1, "relock length")
         `CHK(o_pll_mult, mults[k], "multiplier not in force")
         `CHK(o_sys_half, logic'(mults[k] == 4'h0), "rate after lock")
         if (mults[k] != rcss_pkg::PLL_MULT_BYPASS) begin
            repeat (4) begin
               tick();
               `CHK(o_sysclk_en, 1'b1, "enable not every cycle at full rate")
            end
         end
      end
      $display("test pll relock done");
   endtask : t_pll

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      errors = 0;
      n_checks = 0;
      i_resetn = 1'b0;
      {i_wdog_trip, i_pll_wr, i_clkout_div_wr, sup_go} = 4'h0;
      {i_pll_mult, sup_boot, i_clkout_div} = 10'h000;
      sup_low = 16'h0008;
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_powerup();
      t_warm_div();
      t_wdog();
      t_pll();
      final_report();
   end
endmodule : rcss_tb
`undef CHK
`default_nettype wire
